/* stdm_pkg.sv */
package stdm_pkg;
	localparam int          STDM_DATA_W        = 32;
	localparam int          STDM_ADDR_W        = 8;
	localparam int          STDM_MAX_CH        = 8;
	localparam int          STDM_DUR_FIELD_W   = 4;
	localparam int          STDM_ROLE_FIELD_W  = 2;
	localparam int          STDM_IDX_W         = 3;

	localparam logic [7:0]  STDM_OFS_CTRL      = 8'h00;
	localparam logic [7:0]  STDM_OFS_DUR_SRC   = 8'h04;
	localparam logic [7:0]  STDM_OFS_TRIG_ROLE = 8'h08;
	localparam logic [7:0]  STDM_OFS_TRIG_OUT  = 8'h0c;
	localparam logic [7:0]  STDM_OFS_CUR_CH    = 8'h10;
	localparam logic [7:0]  STDM_OFS_STATUS    = 8'h14;

	localparam int          STDM_CTRL_SEQ_ON   = 0;
	localparam int          STDM_CTRL_TRIG_EN  = 1;
	localparam int          STDM_CTRL_RUN      = 2;
	localparam int          STDM_CTRL_STOP     = 3;
	localparam int          STDM_CTRL_DEF_OUT  = 4;
	localparam int          STDM_CTRL_MARK_IN  = 5;

	localparam int          STDM_STAT_RUN_LSB  = 0;
	localparam int          STDM_STAT_WAIT_LSB = 8;
	localparam int          STDM_STAT_TRIGOUT  = 16;
	localparam int          STDM_STAT_TRIGIN   = 17;

	localparam logic [3:0]  STDM_DUR_OFF       = 4'h0;
	localparam logic [1:0]  STDM_ROLE_OFF      = 2'h0;
	localparam logic [1:0]  STDM_ROLE_IN       = 2'h1;
	localparam logic [1:0]  STDM_ROLE_OUT      = 2'h2;
	localparam logic [1:0]  STDM_ROLE_INOUT    = 2'h3;
	localparam int          STDM_ROLE_IN_BIT   = 0;
	localparam int          STDM_ROLE_OUT_BIT  = 1;

	localparam logic [2:0]  STDM_TRIG_OUT_RST  = 3'h0;
	localparam logic [2:0]  STDM_CUR_CH_RST    = 3'h0;

	typedef enum logic [1:0]
	{
		STDM_IDLE = 2'b00,
		STDM_WAIT = 2'b01,
		STDM_RUN  = 2'b11
	} stdm_state_t;
endpackage

/* stdm_top.sv */
module stdm_top
	import stdm_pkg::*;
#(
	parameter int NUM_CH = STDM_MAX_CH
)
(
	input  wire logic                                I_CLK,
	input  wire logic                                I_RESET_N,
	input  wire logic [STDM_ADDR_W-1:0]              I_ADDR,
	input  wire logic [STDM_DATA_W-1:0]              I_WDATA,
	input  wire logic                                I_WR,
	input  wire logic                                I_RD,
	output logic      [STDM_DATA_W-1:0]              O_RDATA,
	input  wire logic                                I_TRIG_IN,
	input  wire logic [NUM_CH-1:0]                   I_CH_TRIG_SEQ,
	input  wire logic [NUM_CH-1:0]                   I_CH_SEQ_DONE,
	output logic                                     O_TRIG_OUT,
	output logic      [NUM_CH-1:0]                   O_CH_START,
	output logic      [NUM_CH-1:0]                   O_CH_RUN,
	output logic      [NUM_CH-1:0]                   O_CH_WAIT,
	output logic      [NUM_CH-1:0]                   O_CH_SEQ_ON,
	output logic      [NUM_CH*STDM_DUR_FIELD_W-1:0]  O_DUR_SEL
);

	localparam int DUR_W  = NUM_CH * STDM_DUR_FIELD_W;
	localparam int ROLE_W = NUM_CH * STDM_ROLE_FIELD_W;

	if (NUM_CH < 2 || NUM_CH > STDM_MAX_CH)
		$error("NUM_CH must lie between 2 and 8");

	logic [DUR_W-1:0]      dur_src_reg;
	logic [ROLE_W-1:0]     role_reg;
	logic [STDM_IDX_W-1:0] trig_out_src_reg;
	logic [STDM_IDX_W-1:0] cur_ch_reg;
	logic                  seq_on_reg;
	logic                  trig_en_reg;
	logic                  trig_sync1_reg;
	logic                  trig_sync2_reg;
	logic                  trig_sync3_reg;
	logic                  trig_start_reg;
	logic                  trig_out_reg;
	logic [STDM_DATA_W-1:0] rdata_reg;
	logic [NUM_CH-1:0]     start_reg;
	logic [NUM_CH-1:0]     run_reg;
	logic [NUM_CH-1:0]     wait_reg;
	logic [NUM_CH-1:0]     seq_on_ch_reg;
	logic [NUM_CH-1:0]     start_next;
	logic                  any_run;
	logic                  wr_ctrl;
	logic                  run_cmd;
	logic                  stop_cmd;
	stdm_state_t           state_reg  [NUM_CH];
	stdm_state_t           state_next [NUM_CH];

	function automatic logic role_has_in(input logic [1:0] role);
		return role[STDM_ROLE_IN_BIT];
	endfunction

	function automatic logic role_has_out(input logic [1:0] role);
		return role[STDM_ROLE_OUT_BIT];
	endfunction

	// Codes beyond the channel count would point at nothing, so they are stored as off.
	function automatic logic [3:0] clamp_src(input logic [3:0] code);
		if (code > 4'(NUM_CH))
		begin
			return STDM_DUR_OFF;
		end
		return code;
	endfunction

	function automatic logic idx_ok(input logic [STDM_IDX_W-1:0] idx);
		return 32'(idx) < NUM_CH;
	endfunction

	function automatic logic dur_on(input logic [3:0] code);
		return code != STDM_DUR_OFF;
	endfunction

	assign wr_ctrl  = I_WR && (I_ADDR == STDM_OFS_CTRL);
	assign run_cmd  = wr_ctrl && I_WDATA[STDM_CTRL_RUN];
	assign stop_cmd = wr_ctrl && I_WDATA[STDM_CTRL_STOP];
	assign any_run  = |run_reg;

	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			seq_on_reg  <= 1'b0;
			trig_en_reg <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			seq_on_reg  <= I_WDATA[STDM_CTRL_SEQ_ON];
			trig_en_reg <= I_WDATA[STDM_CTRL_TRIG_EN];
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			dur_src_reg <= '0;
		end
		else if (I_WR && I_ADDR == STDM_OFS_DUR_SRC)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				dur_src_reg[i*4 +: 4] <= clamp_src(I_WDATA[i*4 +: 4]);
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
			seq_on_ch_reg <= '0;
		else
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				seq_on_ch_reg[i] <= dur_on(dur_src_reg[i*4 +: 4]);
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
			role_reg <= '0;
		else if (I_WR && I_ADDR == STDM_OFS_TRIG_ROLE)
		begin
			role_reg <= I_WDATA[ROLE_W-1:0];
		end
		else if (wr_ctrl)
		begin
			if (I_WDATA[STDM_CTRL_MARK_IN])
			begin
				role_reg[cur_ch_reg*2 + STDM_ROLE_IN_BIT] <= 1'b1;
			end
			if (I_WDATA[STDM_CTRL_DEF_OUT])
			begin
				role_reg[cur_ch_reg*2 + STDM_ROLE_OUT_BIT] <= 1'b1;
			end
		end
	end

	// A single index, not a mask, makes a second output source impossible to configure.
	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			trig_out_src_reg <= STDM_TRIG_OUT_RST;
		end
		else if (I_WR && I_ADDR == STDM_OFS_TRIG_OUT)
		begin
			if (idx_ok(I_WDATA[STDM_IDX_W-1:0]))
			begin
				trig_out_src_reg <= I_WDATA[STDM_IDX_W-1:0];
			end
		end
		else if (wr_ctrl && I_WDATA[STDM_CTRL_DEF_OUT])
		begin
			trig_out_src_reg <= cur_ch_reg;
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
			cur_ch_reg <= STDM_CUR_CH_RST;
		else if (I_WR && I_ADDR == STDM_OFS_CUR_CH && idx_ok(I_WDATA[STDM_IDX_W-1:0]))
		begin
			cur_ch_reg <= I_WDATA[STDM_IDX_W-1:0];
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			trig_sync1_reg <= 1'b0;
			trig_sync2_reg <= 1'b0;
			trig_sync3_reg <= 1'b0;
			trig_start_reg <= 1'b0;
		end
		else
		begin
			trig_sync1_reg <= I_TRIG_IN;
			trig_sync2_reg <= trig_sync1_reg;
			trig_sync3_reg <= trig_sync2_reg;
			trig_start_reg <= trig_sync2_reg && !trig_sync3_reg && trig_en_reg;
		end
	end

	always_comb
	begin
		for (int i = 0; i < NUM_CH; i++)
		begin
			state_next[i] = state_reg[i];
			start_next[i] = 1'b0;
			unique case (state_reg[i])
				STDM_IDLE:
				begin
					if (run_cmd && seq_on_reg
						&& dur_on(dur_src_reg[i*4 +: 4]))
					begin
						if (role_has_in(role_reg[i*2 +: 2]))
						begin
							state_next[i] = STDM_WAIT;
						end
						else
						begin
							state_next[i] = STDM_RUN;
							start_next[i] = 1'b1;
						end
					end
				end
				STDM_WAIT:
				begin
					if (stop_cmd)
					begin
						state_next[i] = STDM_IDLE;
					end
					else if (trig_start_reg && role_has_in(role_reg[i*2 +: 2])
						&& dur_on(dur_src_reg[i*4 +: 4]))
					begin
						state_next[i] = STDM_RUN;
						start_next[i] = 1'b1;
					end
				end
				STDM_RUN:
				begin
					if (stop_cmd || I_CH_SEQ_DONE[i])
					begin
						state_next[i] = STDM_IDLE;
					end
				end
				default:
				begin
					state_next[i] = STDM_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				state_reg[i] <= STDM_IDLE;
			end
			start_reg <= '0;
			run_reg   <= '0;
			wait_reg  <= '0;
		end
		else
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				state_reg[i] <= state_next[i];
				run_reg[i]   <= state_next[i] == STDM_RUN;
				wait_reg[i]  <= state_next[i] == STDM_WAIT;
			end
			start_reg <= start_next;
		end
	end

	// The source drives the output only while its role has OUT and some channel runs, so a stale index stays silent.
	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
			trig_out_reg <= 1'b0;
		else
		begin
			trig_out_reg <= any_run && role_has_out(role_reg[trig_out_src_reg*2 +: 2])
				&& I_CH_TRIG_SEQ[trig_out_src_reg];
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
			rdata_reg <= '0;
		else
		begin
			rdata_reg <= '0;
			if (I_RD)
			begin
				unique case (I_ADDR)
					STDM_OFS_CTRL:
					begin
						rdata_reg[STDM_CTRL_SEQ_ON]  <= seq_on_reg;
						rdata_reg[STDM_CTRL_TRIG_EN] <= trig_en_reg;
					end
					STDM_OFS_DUR_SRC:   rdata_reg[DUR_W-1:0]      <= dur_src_reg;
					STDM_OFS_TRIG_ROLE: rdata_reg[ROLE_W-1:0]     <= role_reg;
					STDM_OFS_TRIG_OUT:  rdata_reg[STDM_IDX_W-1:0] <= trig_out_src_reg;
					STDM_OFS_CUR_CH:    rdata_reg[STDM_IDX_W-1:0] <= cur_ch_reg;
					STDM_OFS_STATUS:
					begin
						rdata_reg[STDM_STAT_RUN_LSB +: NUM_CH]  <= run_reg;
						rdata_reg[STDM_STAT_WAIT_LSB +: NUM_CH] <= wait_reg;
						rdata_reg[STDM_STAT_TRIGOUT]            <= trig_out_reg;
						rdata_reg[STDM_STAT_TRIGIN]             <= trig_sync2_reg;
					end
					default:            rdata_reg <= '0;
				endcase
			end
		end
	end

	assign O_RDATA     = rdata_reg;
	assign O_TRIG_OUT  = trig_out_reg;
	assign O_CH_START  = start_reg;
	assign O_CH_RUN    = run_reg;
	assign O_CH_WAIT   = wait_reg;
	assign O_CH_SEQ_ON = seq_on_ch_reg;
	assign O_DUR_SEL   = dur_src_reg;

endmodule // stdm_top

/* stdm_checker.sv */
module stdm_checker
	import stdm_pkg::*;
#(
	parameter int NUM_CH = STDM_MAX_CH
)
(
	input wire logic                    I_CLK,
	input wire logic                    I_RESET_N,
	input wire logic [STDM_ADDR_W-1:0]  I_ADDR,
	input wire logic [STDM_DATA_W-1:0]  I_WDATA,
	input wire logic                    I_WR,
	input wire logic                    I_TRIG_IN,
	input wire logic                    O_TRIG_OUT,
	input wire logic [NUM_CH-1:0]       O_CH_START,
	input wire logic [NUM_CH-1:0]       O_CH_RUN,
	input wire logic [NUM_CH-1:0]       O_CH_WAIT,
	input wire logic [NUM_CH-1:0]       O_CH_SEQ_ON
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RESET_N);
	start_once_a: assert property ((O_CH_START & $past(O_CH_START)) == '0)
		else $error("start pulse too long");
	start_runs_a: assert property ((O_CH_START & ~O_CH_RUN) == '0)
		else $error("start without run");
	start_on_a: assert property ((O_CH_START & ~O_CH_SEQ_ON) == '0)
		else $error("disabled channel started");
	trig_out_a: assert property (O_TRIG_OUT |-> $past(|O_CH_RUN))
		else $error("trigger out while idle");
	trig_start_a: assert property (|(O_CH_START & $past(O_CH_WAIT)) |-> $past(I_TRIG_IN, 3))
		else $error("waiting channel started without trigger");
	run_cause_a: assert property (|(O_CH_START & ~$past(O_CH_WAIT)) |->
		$past(I_WR && I_ADDR == STDM_OFS_CTRL && I_WDATA[STDM_CTRL_RUN]))
		else $error("start without run command");
	wait_cause_a: assert property (|(O_CH_WAIT & ~$past(O_CH_WAIT)) |->
		$past(I_WR && I_ADDR == STDM_OFS_CTRL && I_WDATA[STDM_CTRL_RUN]))
		else $error("wait without run command");
	wait_idle_a: assert property ((O_CH_WAIT & O_CH_RUN) == '0)
		else $error("channel waits and runs");
endmodule // stdm_checker

bind stdm_top stdm_checker #(.NUM_CH(NUM_CH)) u_stdm_checker (.I_CLK(I_CLK),
	.I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
	.I_TRIG_IN(I_TRIG_IN), .O_TRIG_OUT(O_TRIG_OUT), .O_CH_START(O_CH_START),
	.O_CH_RUN(O_CH_RUN), .O_CH_WAIT(O_CH_WAIT), .O_CH_SEQ_ON(O_CH_SEQ_ON));

/* stdm_peer.sv */
module stdm_peer
(
	input  wire logic i_clk,
	input  wire logic i_fire,
	output logic      o_trig
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] hold_reg = 4'h0;
	// The line is held ten cycles so the receiving synchroniser cannot miss it.
	always_ff @(posedge i_clk)
	begin
		if (i_fire)
			hold_reg <= 4'ha;
		else if (hold_reg != 4'h0)
			hold_reg <= hold_reg - 4'h1;
	end
	assign o_trig = (hold_reg != 4'h0);
endmodule // stdm_peer

/* tb_sequence_trigger_duration_map.sv */
module tb_sequence_trigger_duration_map import stdm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} stdm_row_t;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        fire = 1'b0;
	logic [7:0]  tseq = 8'h01;
	logic [7:0]  done = 8'h00;
	logic [31:0] rdata;
	logic        trig;
	logic        tout;
	logic [7:0]  start;
	logic [7:0]  run;
	logic [7:0]  wt;
	logic [7:0]  son;
	logic [31:0] dsel;
	logic [31:0] d;
	int          mismatches = 0;
	int          tests_run = 0;
	stdm_row_t   rows [6];
	stdm_top #(.NUM_CH(8)) u_stdm_top (.I_CLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr),
		.I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_TRIG_IN(trig),
		.I_CH_TRIG_SEQ(tseq), .I_CH_SEQ_DONE(done), .O_TRIG_OUT(tout), .O_CH_START(start),
		.O_CH_RUN(run), .O_CH_WAIT(wt), .O_CH_SEQ_ON(son), .O_DUR_SEL(dsel));
	stdm_peer u_stdm_peer (.i_clk(clk), .i_fire(fire), .o_trig(trig));
	always #5 clk = ~clk;
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] w);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= w;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic do_reset();
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
	endtask
	task automatic pulse_peer();
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wait_run(input int ch);
		int n = 0;
		while (run[ch] !== 1'b1 && n < 30)
		begin
			@(posedge clk);
			#1 n++;
		end
		if (run[ch] !== 1'b1)
		begin
			mismatches++;
			conclude();
		end
	endtask
	initial
	begin
		rows = '{'{STDM_OFS_DUR_SRC, 32'h87654321, 32'h87654321},
			'{STDM_OFS_DUR_SRC, 32'h0000009a, 32'h00000000},
			'{STDM_OFS_TRIG_ROLE, 32'h0000e4e4, 32'h0000e4e4},
			'{STDM_OFS_TRIG_OUT, 32'h00000005, 32'h00000005},
			'{STDM_OFS_CUR_CH, 32'h00000006, 32'h00000006},
			'{8'h18, 32'hffffffff, 32'h00000000}};
		do_reset();
		for (int i = 0; i < 6; i++)
		begin
			rd_reg(8'(4 * i), d);
			chk("reset value", d, 32'h0);
		end
		foreach (rows[i])
		begin
			wr_reg(rows[i].a, rows[i].w);
			rd_reg(rows[i].a, d);
			chk("readback", d, rows[i].e);
		end
		do_reset();
		wr_reg(STDM_OFS_DUR_SRC, 32'h00000011);
		wr_reg(STDM_OFS_CUR_CH, 32'h00000001);
		wr_reg(STDM_OFS_CTRL, 32'h00000030);
		wr_reg(STDM_OFS_CUR_CH, 32'h00000003);
		wr_reg(STDM_OFS_CTRL, 32'h00000010);
		wr_reg(STDM_OFS_CUR_CH, 32'h00000000);
		wr_reg(STDM_OFS_CTRL, 32'h00000011);
		chk("duration select", dsel, 32'h00000011);
		rd_reg(STDM_OFS_TRIG_ROLE, d);
		chk("roles", d, 32'h0000008e);
		rd_reg(STDM_OFS_TRIG_OUT, d);
		chk("out source", d, 32'h0);
		wr_reg(STDM_OFS_CTRL, 32'h00000005);
		#1;
		chk("start", 32'(start), 32'h01);
		chk("waiting", 32'(wt), 32'h02);
		chk("seq on", 32'(son), 32'h03);
		rd_reg(STDM_OFS_STATUS, d);
		chk("status", d, 32'h00010201);
		pulse_peer();
		tseq <= 8'h00;
		repeat (12) @(posedge clk);
		#1;
		chk("gated trigger", 32'({tout, wt}), 32'h02);
		wr_reg(STDM_OFS_CTRL, 32'h00000003);
		pulse_peer();
		wait_run(1);
		chk("trigger start", 32'(start), 32'h02);
		chk("wait cleared", 32'(wt), 32'h0);
		@(posedge clk);
		done <= 8'h03;
		@(posedge clk);
		done <= 8'h00;
		repeat (2) @(posedge clk);
		#1;
		chk("finished", 32'({tout, run}), 32'h0);
		wr_reg(STDM_OFS_CTRL, 32'h00000007);
		#1;
		chk("rerun", 32'({wt, run}), 32'h0201);
		wr_reg(STDM_OFS_CTRL, 32'h0000000b);
		#1;
		chk("stopped", 32'(run | wt), 32'h0);
		conclude();
	end
endmodule // tb_sequence_trigger_duration_map
